/* logic/ssr_pkg.sv */
package ssr_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_DATA   = 12'h008;
  localparam logic [11:0] ADDR_CLKDIV = 12'h00C;

  // control register bits
  localparam int CTRL_PORT   = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_CONT   = 2;
  localparam int CTRL_NINE   = 3;
  localparam int CTRL_CLKSRC = 4;
  localparam int CTRL_SYNC  = 5;
  localparam int CTRL_WIDTH = 6;

  // status register bits
  localparam int STAT_RXFLAG = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_NINTH  = 2;
  localparam int STAT_ACTIVE = 3;

  localparam int CHAR_BITS  = 9;
  localparam int BYTE_BITS  = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int DIV_W      = 16;
  localparam logic [DIV_W-1:0] CLKDIV_RESET = 16'h0004;

  typedef struct packed {
    logic serialPortEnable;
    logic singleReceiveEnable;
    logic continuousReceiveEnable;
    logic nineBitReceiveSelect;
    logic clockSourceSelect;
    logic syncMode;
  } ssr_ctrl_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] low;
  } ssr_char_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10
  } ssr_state_t;

endpackage

/* logic/ssr_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module ssr_sync2 (
  input  wire logic clk,   // system clock
  input  wire logic rst,   // async reset
  input  wire logic din,   // async level
  output logic      dout   // synchronised level
);
  logic stage1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

/* logic/ssr_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module ssr_fifo
  import ssr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic      clk,    // system clock
  input  wire logic      rst,    // async reset
  input  wire logic      flush,  // drop all entries
  input  wire logic      push,   // write one character
  input  wire ssr_char_t wdata,  // character in
  input  wire logic      pop,    // drop oldest
  output ssr_char_t      rdata,  // oldest character, registered
  output logic           empty,  // nothing stored
  output logic           full    // no room
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  ssr_char_t       mem [DEPTH];
  logic [AW-1:0]   wptr, rptr, next_wptr, next_rptr;
  logic [CW-1:0]   count, next_count;
  logic            doPush, doPop;

  always_comb begin
    doPush     = push && (count != CW'(DEPTH));
    doPop      = pop && (count != '0);
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    if (flush) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end else begin
      if (doPush) begin
        next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (doPop) begin
        next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      next_count = count + CW'(doPush) - CW'(doPop);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      rdata <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
      if (doPush && !flush) begin
        mem[wptr] <= wdata;
      end
      // read port is registered; a push into an empty fifo bypasses
      if (doPush && !flush && (next_count == CW'(1))) begin
        rdata <= wdata;
      end else if (next_count == '0) begin
        // empty reads as zero, never as an unwritten slot
        rdata <= '0;
      end else begin
        rdata <= mem[next_rptr];
      end
    end
  end

  assign empty = (count == '0);
  assign full  = (count == CW'(DEPTH));
endmodule
`default_nettype wire

/* logic/ssr_receiver.sv */
// Overview of operation
// R1 - master receive disables data pin driver
// R2 - setting single or continuous enable starts reception
// R3 - single mode: one character clocks, then self-clear
// R4 - continuous mode clocks until enable cleared
// R5 - continuous cleared midcharacter: stop, discard partial
// R6 - both set: single clears after first character
// R7 - sample data on trailing clock edge
// R8 - complete character enters fifo, flag set
// R9 - data register shows oldest low byte; flag
// R10 - slave mode takes clock from pin, driver off
// R11 - data changes leading edge, valid trailing edge
// R12 - far master supplies only character bit clocks
// R13 - third character with full fifo sets overrun
// R14 - overrun: stored readable, no new characters accepted
// R15 - overrun not writable; single mode cleared by read
// R16 - continuous overrun cleared by enable or port
// R17 - nine bit select shifts nine bits
// R18 - ninth bit visible in status, read first
// R19 - software sets sync, enable, clock source first
// R20 - reading data register pops oldest entry
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ssr_receiver
  import ssr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic        clk,         // system clock 200 MHz
  input  wire logic        rst,         // async reset, active high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error, unmapped address
  input  wire logic        dataLineIn,  // data line pin level
  output logic             dataLineOut, // data line pin drive value
  output logic             dataLineOe,  // data line enable, low = driving
  input  wire logic        clockLineIn, // clock line pin level
  output logic             clockLineOut,// clock line pin drive value
  output logic             clockLineOe  // clock line enable, low = driving
);

  // ****************************************************************
  // state
  // ****************************************************************
  ssr_ctrl_t        ctrl, next_ctrl;
  logic [DIV_W-1:0] clkDiv, next_clkDiv;
  logic [DIV_W-1:0] divCnt, next_divCnt;
  ssr_state_t       state, next_state;
  logic [CHAR_BITS-1:0] shiftReg, next_shiftReg;
  logic [3:0]       bitCnt, next_bitCnt;
  logic             clkOut, next_clkOut;
  logic             overrun, next_overrun;
  logic             ovrSingle, next_ovrSingle;
  logic             prevCk, next_prevCk;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  logic             next_dataOe, next_clockOe;

  logic             dataSync, ckSync;
  logic             fifoPush, fifoPop, fifoFlush, fifoEmpty, fifoFull;
  ssr_char_t        fifoOut, pushChar;

  logic             wrCtrl, wrDiv, rdData, setup;
  logic             master, charDone, trailEdge, sampleBit;
  logic [3:0]       charLen;

  ssr_sync2 syncData (.clk(clk), .rst(rst), .din(dataLineIn), .dout(dataSync));
  ssr_sync2 syncCk   (.clk(clk), .rst(rst), .din(clockLineIn), .dout(ckSync));

  ssr_fifo #(.DEPTH(DEPTH)) rxFifo (
    .clk   (clk),
    .rst   (rst),
    .flush (fifoFlush),
    .push  (fifoPush),
    .wdata (pushChar),
    .pop   (fifoPop),
    .rdata (fifoOut),
    .empty (fifoEmpty),
    .full  (fifoFull)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup  = psel && !penable;
  assign wrCtrl = setup && pwrite && (paddr == ADDR_CTRL);
  assign wrDiv  = setup && pwrite && (paddr == ADDR_CLKDIV);
  // R20 read pops fifo
  assign rdData = setup && !pwrite && (paddr == ADDR_DATA);
  assign fifoPop = rdData;

  always_comb begin
    next_prdata  = '0;
    next_pready  = setup;
    next_pslverr = 1'b0;
    if (setup && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_prdata[CTRL_WIDTH-1:0] = {ctrl.syncMode, ctrl.clockSourceSelect,
            ctrl.nineBitReceiveSelect, ctrl.continuousReceiveEnable,
            ctrl.singleReceiveEnable, ctrl.serialPortEnable};
        end
        ADDR_STATUS: begin
          // R9 flag while fifo holds data
          next_prdata[STAT_RXFLAG] = !fifoEmpty;
          next_prdata[STAT_OVERRUN] = overrun;
          // R18 ninth bit of oldest
          next_prdata[STAT_NINTH]  = fifoOut.ninth;
          next_prdata[STAT_ACTIVE] = (state != ST_IDLE);
        end
        // R9 low byte of oldest
        ADDR_DATA:   next_prdata[BYTE_BITS-1:0] = fifoOut.low;
        ADDR_CLKDIV: next_prdata[DIV_W-1:0] = clkDiv;
        default:     next_pslverr = 1'b1;
      endcase
    end else if (setup) begin
      next_pslverr = !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_DATA, ADDR_CLKDIV});
    end
  end

  // ****************************************************************
  // receive engine
  // ****************************************************************
  assign master    = ctrl.syncMode && ctrl.clockSourceSelect;
  // R17 nine or eight bits per character
  assign charLen   = ctrl.nineBitReceiveSelect ? 4'(CHAR_BITS) : 4'(BYTE_BITS);
  // R10 slave edges come from the synchronised pin
  assign trailEdge = !master && prevCk && !ckSync;
  // built from the next value so the last sampled bit is included
  assign pushChar  = ctrl.nineBitReceiveSelect
                   ? ssr_char_t'(next_shiftReg)
                   : ssr_char_t'({1'b0, next_shiftReg[CHAR_BITS-1:1]});

  always_comb begin
    next_ctrl      = ctrl;
    next_clkDiv    = clkDiv;
    next_divCnt    = divCnt;
    next_state     = state;
    next_shiftReg  = shiftReg;
    next_bitCnt    = bitCnt;
    next_clkOut    = clkOut;
    next_overrun   = overrun;
    next_ovrSingle = ovrSingle;
    next_prevCk    = ckSync;
    fifoPush       = 1'b0;
    fifoFlush      = 1'b0;
    sampleBit      = 1'b0;
    charDone       = 1'b0;

    // struct field order differs from register bit order: map by index
    if (wrCtrl) begin
      next_ctrl.serialPortEnable        = pwdata[CTRL_PORT];
      next_ctrl.singleReceiveEnable     = pwdata[CTRL_SINGLE];
      next_ctrl.continuousReceiveEnable = pwdata[CTRL_CONT];
      next_ctrl.nineBitReceiveSelect    = pwdata[CTRL_NINE];
      next_ctrl.clockSourceSelect       = pwdata[CTRL_CLKSRC];
      next_ctrl.syncMode                = pwdata[CTRL_SYNC];
    end
    if (wrDiv) begin
      next_clkDiv = pwdata[DIV_W-1:0];
    end

    if (master) begin
      if (state != ST_IDLE) begin
        next_divCnt = (divCnt == '0) ? clkDiv : divCnt - 1'b1;
      end
      if (state == ST_LEAD && divCnt == '0) begin
        next_clkOut = 1'b1;
        next_state  = ST_TRAIL;
      end else if (state == ST_TRAIL && divCnt == '0) begin
        // R7 sample at trailing edge
        next_clkOut = 1'b0;
        sampleBit   = 1'b1;
      end
    end else if (state != ST_IDLE && trailEdge) begin
      sampleBit = 1'b1;
    end

    if (sampleBit) begin
      // R11 data settled since leading edge
      next_shiftReg = {dataSync, shiftReg[CHAR_BITS-1:1]};
      next_bitCnt   = bitCnt + 1'b1;
      next_state    = master ? ST_LEAD : ST_TRAIL;
      if (bitCnt + 1'b1 == charLen) begin
        charDone    = 1'b1;
        next_bitCnt = '0;
      end
    end

    if (charDone) begin
      if (fifoFull) begin
        // R13 overrun keeps fifo intact
        next_overrun   = 1'b1;
        next_ovrSingle = !ctrl.continuousReceiveEnable;
      end else if (!overrun) begin
        // R8 push into fifo
        fifoPush = 1'b1;
      end
      // R3 R6 single enable self-clears
      next_ctrl.singleReceiveEnable = 1'b0;
      if (!ctrl.continuousReceiveEnable) begin
        next_state = ST_IDLE;
      end
    end

    // R15 single-mode overrun cleared by read
    if (rdData && overrun && ovrSingle) begin
      next_overrun = 1'b0;
    end
    // R16 continuous overrun cleared by enable drop
    if (overrun && !ovrSingle && !next_ctrl.continuousReceiveEnable) begin
      next_overrun = 1'b0;
    end

    // R2 R4 start or keep running
    if (state == ST_IDLE && !overrun && ctrl.serialPortEnable && ctrl.syncMode
        && (ctrl.singleReceiveEnable || ctrl.continuousReceiveEnable)) begin
      next_state  = master ? ST_LEAD : ST_TRAIL;
      next_divCnt = clkDiv;
      next_bitCnt = '0;
    end

    // R14 overrun halts reception
    if (overrun && next_overrun) begin
      next_state  = ST_IDLE;
      next_clkOut = 1'b0;
    end

    // R5 drop of enable stops clock, discards partial
    if (state != ST_IDLE && !charDone && !next_ctrl.singleReceiveEnable
        && !next_ctrl.continuousReceiveEnable) begin
      next_state  = ST_IDLE;
      next_clkOut = 1'b0;
      next_bitCnt = '0;
    end

    // R16 port disable resets the port
    if (!next_ctrl.serialPortEnable) begin
      next_state                        = ST_IDLE;
      next_clkOut                       = 1'b0;
      next_bitCnt                       = '0;
      next_overrun                      = 1'b0;
      next_ctrl.singleReceiveEnable     = 1'b0;
      next_ctrl.continuousReceiveEnable = 1'b0;
      fifoFlush                         = 1'b1;
      fifoPush                          = 1'b0;
    end
  end

  // R1 R10 pins are inputs except master clock output
  assign next_dataOe  = 1'b1;
  assign next_clockOe = !(ctrl.serialPortEnable && master);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl         <= '0;
      clkDiv       <= CLKDIV_RESET;
      divCnt       <= '0;
      state        <= ST_IDLE;
      shiftReg     <= '0;
      bitCnt       <= '0;
      clkOut       <= 1'b0;
      overrun      <= 1'b0;
      ovrSingle    <= 1'b0;
      prevCk       <= 1'b0;
      prdata       <= '0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      dataLineOut  <= 1'b0;
      dataLineOe   <= 1'b1;
      clockLineOut <= 1'b0;
      clockLineOe  <= 1'b1;
    end else begin
      ctrl         <= next_ctrl;
      clkDiv       <= next_clkDiv;
      divCnt       <= next_divCnt;
      state        <= next_state;
      shiftReg     <= next_shiftReg;
      bitCnt       <= next_bitCnt;
      clkOut       <= next_clkOut;
      overrun      <= next_overrun;
      ovrSingle    <= next_ovrSingle;
      prevCk       <= next_prevCk;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      dataLineOut  <= 1'b0;
      dataLineOe   <= next_dataOe;
      clockLineOut <= next_clkOut;
      clockLineOe  <= next_clockOe;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence charEnd_s;
    charDone && fifoFull;
  endsequence

  data_pin_off_a: assert property (dataLineOe == 1'b1) // R1
    else $error("data line driven");
  start_rx_a: assert property (state == ST_IDLE && !overrun && ctrl.serialPortEnable && !wrCtrl
      && ctrl.syncMode && ctrl.continuousReceiveEnable |=> state != ST_IDLE) // R2
    else $error("reception did not start");
  single_clear_a: assert property (charDone |=> !ctrl.singleReceiveEnable) // R3
    else $error("single enable not cleared");
  bit_count_a: assert property (bitCnt < 4'(CHAR_BITS)) // R17
    else $error("bit count past character");
  stop_clock_a: assert property (state != ST_IDLE && !next_ctrl.continuousReceiveEnable
      && !next_ctrl.singleReceiveEnable && !charDone |=> state == ST_IDLE && !clkOut) // R5
    else $error("clock not stopped");
  push_flag_a: assert property (fifoPush |=> !fifoEmpty) // R8
    else $error("flag not set after push");
  overrun_set_a: assert property (charEnd_s |=> overrun) // R13
    else $error("overrun not flagged");
  overrun_hold_a: assert property (overrun |-> !fifoPush) // R14
    else $error("character accepted during overrun");
  slave_pin_a: assert property (!master |=> clockLineOe) // R10
    else $error("clock pin driven in slave mode");
  port_off_a: assert property (!next_ctrl.serialPortEnable |=> !overrun && fifoEmpty) // R16
    else $error("port disable did not clear");
endmodule
`default_nettype wire

/* sim/ssr_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// far-end synchronous peer: sends characters, lsb first
// ****************************************************************
module ssr_peer (
  input  wire logic clockIn,  // resolved clock line level
  input  wire logic clockOe,  // receiver clock enable, low = receiver drives
  input  wire logic nine,     // nine bits per character
  output logic      dataOut,  // data line level from the peer
  output logic      clockOut  // clock line level in slave mode
);
  logic [8:0] txq [$];
  int         idx;

  initial begin
    dataOut  = 1'b0;
    clockOut = 1'b0;
    idx      = 0;
  end

  task automatic push(input logic [8:0] c);
    txq.push_back(c);
  endtask

  task automatic clear();
    txq.delete();
    idx = 0;
  endtask

  function automatic int nbits();
    return nine ? 9 : 8;
  endfunction

  always @(posedge clockIn) begin
    if (!clockOe) begin
      if (txq.size() == 0) begin
        // nothing queued: no stale level may pass for data
        dataOut = ~dataOut;
      end else begin
        dataOut = txq[0][idx];
        idx++;
        if (idx == nbits()) begin
          idx = 0;
          void'(txq.pop_front());
        end
      end
    end
  end

  // one clock per data bit, clock idles low
  task automatic slave_frame(input logic [8:0] c);
    // 6.5 ns offset keeps the first link edge off the system clock edges
    #6.5;
    for (int i = 0; i < nbits(); i++) begin
      clockOut = 1'b1;
      dataOut  = c[i];
      #24;
      clockOut = 1'b0;
      #24;
    end
    dataOut = ~dataOut;
  endtask
endmodule
`default_nettype wire

/* sim/sync_serial_receiver_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sync_serial_receiver_bench;
  import ssr_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk, rst, psel, penable, pwrite, nineSel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic        pready, pslverr, dataLineOut, dataLineOe, clockLineOut, clockLineOe;
  logic        peerData, peerClk;
  logic [32:0] expQ [$];
  logic [32:0] mskQ [$];
  logic [8:0]  c [3];
  int          errTotal, checks, cyc, edges;
  integer      seed;
  wire logic   dataWire = dataLineOe ? peerData : dataLineOut;
  wire logic   clkWire  = clockLineOe ? peerClk : clockLineOut;

  ssr_receiver dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dataLineIn(dataWire), .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe), .clockLineIn(clkWire), .clockLineOut(clockLineOut),
    .clockLineOe(clockLineOe)
  );

  ssr_peer peer (
    .clockIn(clkWire), .clockOe(clockLineOe), .nine(nineSel),
    .dataOut(peerData), .clockOut(peerClk)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clockLineOut) edges++;

  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // a hang ends here instead of running forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errTotal++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  // oldest note against each completed read; mask zero marks a poll
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && mskQ.size() > 0) begin
      if (mskQ[0] != '0) check({pslverr, prdata} & mskQ[0], expQ[0], "apb read");
      void'(mskQ.pop_front());
      void'(expQ.pop_front());
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err = 1'b0);
    logic [31:0] r;
    expQ.push_back({err, e & m});
    mskQ.push_back({1'b1, m});
    apb(1'b0, a, '0, r);
  endtask

  task automatic waitBit(input logic [11:0] a, input int b, input logic val);
    logic [31:0] r;
    r = {32{~val}};
    while (r[b] !== val) begin
      expQ.push_back('0);
      mskQ.push_back('0);
      apb(1'b0, a, '0, r);
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 32'hF69DCB13;
    {rst, psel, penable, pwrite, nineSel} = 5'b10000;
    paddr  = '0;
    pwdata = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check(dataLineOe, 1, "data pin released");
    check(dataLineOut, 0, "data pin drive low");
    check(clockLineOe, 1, "clock pin released at reset");
    rd(ADDR_CTRL, 0, ALL);
    rd(ADDR_STATUS, 0, ALL);
    rd(ADDR_CLKDIV, 32'(CLKDIV_RESET), ALL);
    wr(ADDR_CLKDIV, 32'h5);
    rd(ADDR_CLKDIV, 32'h5, ALL);
    rd(12'h010, 0, ALL, 1'b1);
    $display("test reset done");

    c[0] = 9'($random(seed));
    peer.push(c[0]);
    edges = 0;
    wr(ADDR_CTRL, 32'h33);
    waitBit(ADDR_STATUS, STAT_RXFLAG, 1'b1);
    check(edges, 8, "single mode pulses");
    check(clockLineOe, 0, "master drives clock");
    check(dataLineOe, 1, "data pin only samples");
    rd(ADDR_CTRL, 32'h31, ALL);
    rd(ADDR_DATA, {24'h0, c[0][7:0]}, ALL);
    rd(ADDR_STATUS, 0, 32'h7);
    $display("test single done");

    nineSel = 1'b1;
    edges   = 0;
    for (int i = 0; i < 3; i++) begin
      c[i] = 9'($random(seed));
      peer.push(c[i]);
      wr(ADDR_CTRL, 32'h3B);
      waitBit(ADDR_CTRL, CTRL_SINGLE, 1'b0);
    end
    check(edges, 27, "nine bit pulses");
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 32'({c[0][8], 2'b11}), 32'h7);
    rd(ADDR_DATA, {24'h0, c[0][7:0]}, ALL);
    rd(ADDR_STATUS, 32'({c[1][8], 2'b01}), 32'h7);
    rd(ADDR_DATA, {24'h0, c[1][7:0]}, ALL);
    rd(ADDR_STATUS, 0, 32'h3);
    $display("test nine bit overrun done");

    nineSel = 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++) begin
        c[i] = 9'($random(seed));
        peer.push(c[i]);
      end
      edges = 0;
      wr(ADDR_CTRL, 32'h37);
      waitBit(ADDR_STATUS, STAT_OVERRUN, 1'b1);
      check(edges, 24, "continuous pulses");
      rd(ADDR_CTRL, 32'h35, 32'h3F);
      wr(ADDR_CTRL, (m == 0) ? 32'h31 : 32'h0);
      peer.clear();
      rd(ADDR_STATUS, (m == 0) ? 32'h1 : 32'h0, 32'h3);
      if (m == 0) begin
        rd(ADDR_DATA, {24'h0, c[0][7:0]}, ALL);
        rd(ADDR_DATA, {24'h0, c[1][7:0]}, ALL);
      end
    end
    $display("test continuous overrun done");

    peer.push(9'h0A5);
    edges = 0;
    wr(ADDR_CTRL, 32'h35);
    while (edges < 3) @(posedge clk);
    wr(ADDR_CTRL, 32'h31);
    edges = 0;
    repeat (40) @(posedge clk);
    check(edges, 0, "clock stopped");
    check(clockLineOut, 0, "clock idle");
    rd(ADDR_STATUS, 0, 32'h9);
    peer.clear();
    $display("test abort done");

    wr(ADDR_CTRL, 32'h25);
    c[0] = 9'($random(seed));
    peer.slave_frame(c[0]);
    check(clockLineOe, 1, "slave clock pin released");
    waitBit(ADDR_STATUS, STAT_RXFLAG, 1'b1);
    rd(ADDR_DATA, {24'h0, c[0][7:0]}, ALL);
    wr(ADDR_CTRL, 32'h0);
    $display("test slave done");
    summarize();
  end
endmodule
`default_nettype wire
